// [shared/fce_consts.svh]
// Register offsets, field positions, reset values for the fault check and alert enable bank
`ifndef FCE_CONSTS_SVH
`define FCE_CONSTS_SVH

// ============================================================
// Register offsets
`define FCE_ADDR_NOTIFY_EN      8'h19
`define FCE_ADDR_HIGH_EN        8'h1A
`define FCE_ADDR_LOW_EN         8'h1B
`define FCE_ADDR_AUX_COLD_EN    8'h1C

// ============================================================
// Reset values
`define FCE_RST_NOTIFY_EN       16'hBFFF
`define FCE_RST_HIGH_EN         16'h0000
`define FCE_RST_LOW_EN          16'h0000
`define FCE_RST_AUX_COLD_EN     4'h0

// ============================================================
// Field positions in the notify and high/low enable registers, and cell and aux field widths
`define FCE_BIT_SCAN            15
`define FCE_BIT_PACKET          5
`define FCE_BIT_CS              15
`define FCE_BIT_BLOCK           14
`define FCE_CELLS               14
`define FCE_AUX                 4
`define FCE_NOTIFY_USED         16'hBFFF

`endif

// [shared/fce_pkg.sv]
// Types shared by the fault check and alert enable bank
package fce_pkg;

	// ============================================================
	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} fce_bus_req_t;

	// ============================================================
	// Per-channel check enables handed to the scan engine
	typedef struct packed {
		logic        cs_high;
		logic        block_high;
		logic [13:0] cell_high;
		logic        cs_low;
		logic        block_low;
		logic [13:0] cell_low;
		logic [3:0]  aux_cold;
	} fce_check_en_t;

	// ============================================================
	// Flag clear pulses when an enable bit falls
	typedef struct packed {
		logic        cs_high;
		logic        block_high;
		logic [13:0] cell_high;
		logic        cs_low;
		logic        block_low;
		logic [13:0] cell_low;
		logic [3:0]  aux_cold;
	} fce_flag_clr_t;

endpackage

// [rtl/fce_enreg.sv]
// One writable enable register with fall-edge clear pulses
`timescale 1ns/10ps
`default_nettype none

module fce_enreg #(
	parameter int          W     = 16,
	parameter logic [W-1:0] RST  = '0
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] value,
	output logic      [W-1:0] fell
);

	logic [W-1:0] value_reg;
	logic [W-1:0] value_next;
	logic [W-1:0] fell_reg;

	// ============================================================
	// Next value and falling bits
	assign value_next = wr_en ? wdata : value_reg;

	// Fell pulse lasts one cycle after the write that cleared the bit
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			value_reg <= RST;
			fell_reg  <= '0;
		end else begin
			value_reg <= value_next;
			fell_reg  <= value_reg & ~value_next;
		end
	end

	assign value = value_reg;
	assign fell  = fell_reg;

endmodule

`default_nettype wire

// [rtl/fce_bank.sv]
// Fault check enables and alert notification gating
`timescale 1ns/10ps
`default_nettype none

`include "fce_consts.svh"

module fce_bank (
	input  wire logic                 mclk,
	input  wire logic                 reset_n,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	input  wire logic [15:0]          primary_status_reg,
	input  wire logic                 scan_active,
	input  wire logic [3:0]           aux_two_wire_mode,
	input  wire logic [3:0]           aux_pin_io_mode,
	output fce_pkg::fce_check_en_t    check_en,
	output fce_pkg::fce_flag_clr_t    flag_clr,
	output logic      [15:0]          primary_status_view,
	output logic                      alert_pin,
	output logic                      chain_status_alert,
	output logic                      alert_packet_flag,
	output logic                      spi_alert_bit
);

	// ============================================================
	// Bus request bundle and address decode
	fce_pkg::fce_bus_req_t req;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	wire hit_notify = req.addr == `FCE_ADDR_NOTIFY_EN;
	wire hit_high   = req.addr == `FCE_ADDR_HIGH_EN;
	wire hit_low    = req.addr == `FCE_ADDR_LOW_EN;
	wire hit_aux    = req.addr == `FCE_ADDR_AUX_COLD_EN;

	// ============================================================
	// Enable registers
	logic [15:0] notify_en;
	logic [15:0] high_en;
	logic [15:0] low_en;
	logic [3:0]  aux_en;
	logic [15:0] high_fell;
	logic [15:0] low_fell;
	logic [3:0]  aux_fell;

	// Unused notify bit 14 is forced to zero so it reads back as zero
	fce_enreg #(.W(16), .RST(`FCE_RST_NOTIFY_EN)) u_notify (
		.mclk    (mclk),
		.reset_n (reset_n),
		.wr_en   (req.wr & hit_notify),
		.wdata   (req.wdata & `FCE_NOTIFY_USED),
		.value   (notify_en),
		.fell    ()
	);

	// Reset to zero: no check runs until software asks for it
	fce_enreg #(.W(16), .RST(`FCE_RST_HIGH_EN)) u_high (
		.mclk    (mclk),
		.reset_n (reset_n),
		.wr_en   (req.wr & hit_high),
		.wdata   (req.wdata),
		.value   (high_en),
		.fell    (high_fell)
	);

	fce_enreg #(.W(16), .RST(`FCE_RST_LOW_EN)) u_low (
		.mclk    (mclk),
		.reset_n (reset_n),
		.wr_en   (req.wr & hit_low),
		.wdata   (req.wdata),
		.value   (low_en),
		.fell    (low_fell)
	);

	// Aux bits keep the value written, whatever the pin mode
	fce_enreg #(.W(4), .RST(`FCE_RST_AUX_COLD_EN)) u_aux (
		.mclk    (mclk),
		.reset_n (reset_n),
		.wr_en   (req.wr & hit_aux),
		.wdata   (req.wdata[3:0]),
		.value   (aux_en),
		.fell    (aux_fell)
	);

	// ============================================================
	// Read port: data one cycle after the strobe, zero elsewhere
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	wire  [15:0] rd_mux = hit_notify ? notify_en :
	                      hit_high   ? high_en :
	                      hit_low    ? low_en :
	                      hit_aux    ? {12'h000, aux_en} : 16'h0000;
	assign rdata_next = req.rd ? rd_mux : 16'h0000;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// ============================================================
	// Check enables, qualified by scan activity
	wire [3:0] aux_usable = ~aux_pin_io_mode & ~{2'b00, aux_two_wire_mode[1:0]};

	assign check_en.cs_high    = scan_active & high_en[`FCE_BIT_CS];
	assign check_en.block_high = scan_active & high_en[`FCE_BIT_BLOCK];
	assign check_en.cell_high  = {`FCE_CELLS{scan_active}} & high_en[13:0];
	assign check_en.cs_low     = scan_active & low_en[`FCE_BIT_CS];
	assign check_en.block_low  = scan_active & low_en[`FCE_BIT_BLOCK];
	assign check_en.cell_low   = {`FCE_CELLS{scan_active}} & low_en[13:0];
	assign check_en.aux_cold   = {`FCE_AUX{scan_active}} & aux_en & aux_usable;

	// ============================================================
	// Clear pulses to the flag owners when an enable falls
	assign flag_clr.cs_high    = high_fell[`FCE_BIT_CS];
	assign flag_clr.block_high = high_fell[`FCE_BIT_BLOCK];
	assign flag_clr.cell_high  = high_fell[13:0];
	assign flag_clr.cs_low     = low_fell[`FCE_BIT_CS];
	assign flag_clr.block_low  = low_fell[`FCE_BIT_BLOCK];
	assign flag_clr.cell_low   = low_fell[13:0];
	assign flag_clr.aux_cold   = aux_fell;

	// ============================================================
	// Notification gating
	// Status passes through unmasked so software always sees raw data
	assign primary_status_view = primary_status_reg;

	wire [15:0] gated = primary_status_reg & notify_en;

	// Byte excludes packet alert and scan alert; pin takes scan alert too
	wire [15:0] byte_mask = ~(16'h0001 << `FCE_BIT_PACKET) & ~(16'h0001 << `FCE_BIT_SCAN);
	wire [15:0] pkt_mask  = ~(16'h0001 << `FCE_BIT_SCAN);

	assign alert_pin          = |gated;
	assign chain_status_alert = |(gated & byte_mask);
	assign alert_packet_flag  = |(gated & pkt_mask);
	assign spi_alert_bit      = |(gated & pkt_mask);

endmodule

`default_nettype wire

// [tb/fce_host.sv]
// Host bus master model for the enable bank
`timescale 1ns/10ps
`default_nettype none
module fce_host (
	input  wire logic        mclk,
	output var logic  [7:0]  reg_addr = 8'h00,
	output var logic  [15:0] reg_wdata = 16'h0000,
	output var logic         reg_wr = 1'b0,
	output var logic         reg_rd = 1'b0,
	input  wire logic [15:0] reg_rdata
);
	// ====
	// Bus cycles; strobes last one cycle and change just after the edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// [tb/fce_bank_sva.sv]
// Port assertions for the enable bank
`timescale 1ns/10ps
`default_nettype none
module fce_bank_sva (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] primary_status_reg,
	input wire logic scan_active,
	input wire fce_pkg::fce_check_en_t check_en,
	input wire logic [15:0] primary_status_view,
	input wire logic alert_pin,
	input wire logic chain_status_alert,
	input wire logic alert_packet_flag,
	input wire logic spi_alert_bit
);
	// ====
	// One clock; every check is off while reset is low
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	spi_mirror_a: assert property (spi_alert_bit == alert_packet_flag) else $error("spi");
	pkt_in_pin_a: assert property (alert_packet_flag |-> alert_pin) else $error("pin");
	byte_in_pkt_a: assert property (chain_status_alert |-> alert_packet_flag) else $error("byte");
	byte_no_pec_a: assert property ((primary_status_reg & 16'h3FDF) == 16'h0000
		|-> !chain_status_alert) else $error("byte pec");
	view_raw_a: assert property (primary_status_view == primary_status_reg) else $error("view");
	no_scan_a: assert property (!scan_active |-> check_en == '0) else $error("scan");
	idle_quiet_a: assert property (primary_status_reg == 16'h0000 |-> !alert_pin) else $error("idle");
	notify_rst_a: assert property ($rose(reset_n) ##1 reg_rd && reg_addr == 8'h19
		|=> reg_rdata == 16'hBFFF) else $error("notify reset");
	// Main scenarios reached
	cover property (alert_pin && !alert_packet_flag);
	cover property (chain_status_alert);
	cover property (scan_active && check_en != '0);
endmodule
bind fce_bank fce_bank_sva i_fce_bank_sva (.*);
`default_nettype wire

// [tb/fault_check_alert_enables_bench.sv]
// Self-checking bench for the enable bank
`timescale 1ns/10ps
`default_nettype none
module fault_check_alert_enables_bench;
	logic mclk, reg_wr, reg_rd, alert_pin, chain_status_alert, alert_packet_flag, spi_alert_bit;
	logic reset_n = 1'b0, scan_active = 1'b0;
	logic [3:0] aux_two_wire_mode = 4'h0, aux_pin_io_mode = 4'h0, m_a = 4'h0;
	logic [7:0] reg_addr;
	logic [15:0] primary_status_reg = 16'h0000, reg_wdata, reg_rdata, primary_status_view, d;
	logic [15:0] m_n = 16'hBFFF, m_h = 16'h0000, m_l = 16'h0000;
	fce_pkg::fce_check_en_t check_en;
	fce_pkg::fce_flag_clr_t flag_clr;
	int fails = 0, samples_checked = 0;
	fce_bank i_fce_bank (.*);
	fce_host i_fce_host (.*);
	// ====
	// Clock, and a cycle ceiling that cuts a hang short
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (9000) @(posedge mclk);
		fails++;
		print_verdict();
	end
	// Compare and count
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp) fails++;
		if (seen !== exp) $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Write, read back, then apply new alerts and check every output
	task automatic step(input logic [7:0] a, input logic [15:0] v, input logic [15:0] s);
		logic [35:0] was;
		logic [15:0] on;
		was = {m_h, m_l, m_a};
		i_fce_host.wr(a, v);
		if (a == 8'h19) m_n = v & 16'hBFFF;
		if (a == 8'h1A) m_h = v;
		if (a == 8'h1B) m_l = v;
		if (a == 8'h1C) m_a = v[3:0];
		chk(flag_clr, was & ~{m_h, m_l, m_a});
		i_fce_host.rd(a, d);
		chk(d, a == 8'h19 ? m_n : a == 8'h1A ? m_h : a == 8'h1B ? m_l : a == 8'h1C ? {12'h000, m_a}
			: 16'h0000);
		@(posedge mclk);
		primary_status_reg <= s;
		{scan_active, aux_two_wire_mode, aux_pin_io_mode} <= 9'($urandom);
		#1 on = s & m_n;
		chk(alert_pin, |on);
		d = {13'h0000, |(on & 16'h3FDF), |(on & 16'h7FFF), |(on & 16'h7FFF)};
		chk({chain_status_alert, alert_packet_flag, spi_alert_bit}, d);
		chk(primary_status_view, s);
		was = {m_h, m_l, m_a & ~(aux_pin_io_mode | {2'b00, aux_two_wire_mode[1:0]})};
		chk(check_en, scan_active ? was : 36'h0);
	endtask
	// Reset values, each summary bit shut then open, then random traffic
	initial begin
		void'($urandom(32'h54C7CABA));
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		for (int a = 25; a < 31; a++) begin
			i_fce_host.rd(8'(a), d);
			chk(d, a == 25 ? 16'hBFFF : 16'h0000);
		end
		for (int b = 0; b < 32; b++) begin
			step(8'h19, b[4] ? 16'hFFFF : ~(16'h0001 << b[3:0]), 16'h0001 << b[3:0]);
		end
		repeat (300) begin
			step(8'h18 + 8'($urandom_range(0, 5)), 16'($urandom), 16'($urandom));
		end
		print_verdict();
	end
endmodule
`default_nettype wire
